// ### dsp_dimm_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_dimm_model (
    // Clock
    input  wire logic        i_clk_sys,
    // Controller pins
    input  wire logic [1:0]  i_bank_addr,
    input  wire logic [12:0] i_mux_addr,
    input  wire logic [7:0]  i_chip_sel_n,
    input  wire logic [3:0]  i_row_strobe_n,
    input  wire logic [3:0]  i_col_strobe_n,
    input  wire logic [3:0]  i_write_strobe_n,
    input  wire logic [71:0] i_data_n,
    input  wire logic        i_data_oe,
    // Resolved data lines
    output logic      [71:0] o_bus_n
);
    logic [71:0] mem_q [bit [32:0]];
    logic [14:0] row_q = 15'h0000;
    logic [71:0] drv_q = 72'h0;
    int          hold_q = 0;
    assign o_bus_n = i_data_oe ? i_data_n : drv_q;
    always @(negedge i_clk_sys) begin
        logic [4:0] dimm;
        dimm = 5'h00;
        for (int i = 0; i < 8; i++) if (!i_chip_sel_n[i]) dimm[2:0] = 3'(i);
        for (int g = 0; g < 4; g++) if (!(i_row_strobe_n[g] && i_col_strobe_n[g])) dimm[4:3] = 2'(g);
        hold_q <= hold_q > 0 ? hold_q - 1 : 0;
        // Released lines toggle so stale data never looks valid
        drv_q <= hold_q > 0 ? drv_q : ~drv_q;
        if (i_row_strobe_n != 4'hF) row_q <= {i_bank_addr, i_mux_addr};
        if (i_col_strobe_n != 4'hF) begin
            if (i_write_strobe_n != 4'hF) mem_q[{dimm, row_q, i_mux_addr}] = ~i_data_n;
            else begin
                drv_q <= ~mem_q[{dimm, row_q, i_mux_addr}];
                hold_q <= 3;
            end
        end
    end
endmodule
`default_nettype wire

// ### dsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_arst_n,
    input  wire logic             i_ce,
    // Fill side
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    // Drain side
    output logic                  o_valid,
    output logic      [WIDTH-1:0] o_data,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } dsp_fifo_st_t;

    dsp_fifo_st_t     s_q;
    dsp_fifo_st_t     s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             push;
    logic             pop;

    assign o_ready = (s_q.cnt != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign o_valid = (s_q.cnt != '0);
    assign o_data  = mem_q[s_q.rd];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + AW'(1);
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + AW'(1);
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_ce && push) begin
            mem_q[s_q.wr] <= i_data;
        end
    end

    fifo_cap_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        s_q.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule
`default_nettype wire

// ### dsp_pkg.sv
package dsp_pkg;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 13;
    localparam int CS_N       = 8;
    localparam int GRP_N      = 4;
    localparam int DATA_W     = 64;
    localparam int CHK_W      = 8;
    localparam int WORD_W     = DATA_W + CHK_W;
    localparam int DIMM_W     = 5;
    localparam int I2C_N      = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int CS_SHIFT   = 3;
    localparam logic [CS_N-1:0]  CS_IDLE  = 8'hFF;
    localparam logic [GRP_N-1:0] GRP_IDLE = 4'hF;
    // Cycles a read word spends in the two pin flops
    localparam logic [1:0]       RD_SYNC_CYC = 2'h2;

    typedef enum logic [1:0] {
        DSP_CMD_NOP,
        DSP_CMD_ROW,
        DSP_CMD_COL
    } dsp_cmd_t;

    typedef enum {
        DSP_ST_IDLE,
        DSP_ST_COL,
        DSP_ST_DATA
    } dsp_state_t;
endpackage

// ### dsp_port.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_port #(
    parameter int FIFO_DEPTH = dsp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_arst_n,
    input  wire logic                       i_ce,
    // Command request
    input  wire logic                       i_cmd_valid,
    output logic                            o_cmd_ready,
    input  wire logic                       i_cmd_write,
    input  wire logic [dsp_pkg::DIMM_W-1:0] i_cmd_dimm,
    input  wire logic [dsp_pkg::BANK_W-1:0] i_cmd_bank,
    input  wire logic [dsp_pkg::ADDR_W-1:0] i_cmd_row,
    input  wire logic [dsp_pkg::ADDR_W-1:0] i_cmd_col,
    // Write data stream
    input  wire logic                       i_wr_valid,
    output logic                            o_wr_ready,
    input  wire logic [dsp_pkg::WORD_W-1:0] i_wr_data,
    // Read data
    output logic                            o_rd_valid,
    output logic      [dsp_pkg::WORD_W-1:0] o_rd_data,
    // Memory pins
    output logic      [dsp_pkg::BANK_W-1:0] o_bank_addr,
    output logic      [dsp_pkg::ADDR_W-1:0] o_mux_addr,
    output logic      [dsp_pkg::CS_N-1:0]   o_chip_sel_n,
    output logic      [dsp_pkg::GRP_N-1:0]  o_row_strobe_n,
    output logic      [dsp_pkg::GRP_N-1:0]  o_col_strobe_n,
    output logic      [dsp_pkg::GRP_N-1:0]  o_write_strobe_n,
    input  wire logic [dsp_pkg::WORD_W-1:0] i_data_n,
    output logic      [dsp_pkg::WORD_W-1:0] o_data_n,
    output logic                            o_data_oe
);
    typedef struct packed {
        dsp_pkg::dsp_state_t          st;
        logic [dsp_pkg::BANK_W-1:0]   bank;
        logic [dsp_pkg::ADDR_W-1:0]   addr;
        logic [dsp_pkg::ADDR_W-1:0]   col;
        logic [dsp_pkg::CS_N-1:0]     cs_n;
        logic [dsp_pkg::GRP_N-1:0]    ras_n;
        logic [dsp_pkg::GRP_N-1:0]    cas_n;
        logic [dsp_pkg::GRP_N-1:0]    we_n;
        logic [dsp_pkg::CS_N-1:0]     cs_sel;
        logic [dsp_pkg::GRP_N-1:0]    grp_sel;
        logic                         wr;
        logic [dsp_pkg::WORD_W-1:0]   dout_n;
        logic                         oe;
        logic [dsp_pkg::WORD_W-1:0]   din_s1;
        logic [dsp_pkg::WORD_W-1:0]   din_s2;
        logic                         rvalid;
        logic [dsp_pkg::WORD_W-1:0]   rdata;
        logic [1:0]                   dly;
    } dsp_port_st_t;

    dsp_port_st_t               s_q;
    dsp_port_st_t               s_d;
    logic                       f_valid;
    logic                       f_take;
    logic [dsp_pkg::WORD_W-1:0] f_data;

    dsp_fifo #(
        .WIDTH (dsp_pkg::WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_valid   (i_wr_valid),
        .i_data    (i_wr_data),
        .o_ready   (o_wr_ready),
        .o_valid   (f_valid),
        .o_data    (f_data),
        .i_ready   (f_take)
    );

    // Write needs data already buffered before the command is accepted
    assign o_cmd_ready = (s_q.st == dsp_pkg::DSP_ST_IDLE) && (!i_cmd_write || f_valid);
    assign f_take      = i_cmd_valid && o_cmd_ready && i_cmd_write;

    always_comb begin
        s_d        = s_q;
        s_d.din_s1 = i_data_n;
        s_d.din_s2 = s_q.din_s1;
        s_d.cs_n   = dsp_pkg::CS_IDLE;
        s_d.ras_n  = dsp_pkg::GRP_IDLE;
        s_d.cas_n  = dsp_pkg::GRP_IDLE;
        s_d.we_n   = dsp_pkg::GRP_IDLE;
        s_d.rvalid = 1'b0;
        case (s_q.st)
            dsp_pkg::DSP_ST_IDLE: begin
                s_d.oe = 1'b0;
                if (i_cmd_valid && o_cmd_ready) begin
                    // Low three bits pick the select, upper two the group
                    s_d.cs_sel  = ~(dsp_pkg::CS_N'(1) << i_cmd_dimm[dsp_pkg::CS_SHIFT-1:0]);
                    s_d.grp_sel = ~(dsp_pkg::GRP_N'(1)
                                   << i_cmd_dimm[dsp_pkg::DIMM_W-1:dsp_pkg::CS_SHIFT]);
                    s_d.cs_n    = ~(dsp_pkg::CS_N'(1) << i_cmd_dimm[dsp_pkg::CS_SHIFT-1:0]);
                    s_d.ras_n   = s_d.grp_sel;
                    s_d.bank    = i_cmd_bank;
                    s_d.addr    = i_cmd_row;
                    s_d.col     = i_cmd_col;
                    s_d.wr      = i_cmd_write;
                    s_d.dout_n  = ~f_data;
                    s_d.st      = dsp_pkg::DSP_ST_COL;
                end
            end
            dsp_pkg::DSP_ST_COL: begin
                s_d.cs_n  = s_q.cs_sel;
                s_d.cas_n = s_q.grp_sel;
                s_d.we_n  = s_q.wr ? s_q.grp_sel : dsp_pkg::GRP_IDLE;
                s_d.addr  = s_q.col;
                s_d.oe    = s_q.wr;
                s_d.dly   = '0;
                s_d.st    = dsp_pkg::DSP_ST_DATA;
            end
            dsp_pkg::DSP_ST_DATA: begin
                s_d.oe = 1'b0;
                if (s_q.wr) begin
                    s_d.st = dsp_pkg::DSP_ST_IDLE;
                end else if (s_q.dly == dsp_pkg::RD_SYNC_CYC) begin
                    // Read word has now crossed both pin flops
                    s_d.rvalid = 1'b1;
                    s_d.rdata  = ~s_q.din_s2;
                    s_d.st     = dsp_pkg::DSP_ST_IDLE;
                end else begin
                    s_d.dly = s_q.dly + 2'h1;
                end
            end
            default: begin
                s_d.st = dsp_pkg::DSP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q       <= '0;
            s_q.st    <= dsp_pkg::DSP_ST_IDLE;
            s_q.cs_n  <= dsp_pkg::CS_IDLE;
            s_q.ras_n <= dsp_pkg::GRP_IDLE;
            s_q.cas_n <= dsp_pkg::GRP_IDLE;
            s_q.we_n  <= dsp_pkg::GRP_IDLE;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_bank_addr      = s_q.bank;
    assign o_mux_addr       = s_q.addr;
    assign o_chip_sel_n     = s_q.cs_n;
    assign o_row_strobe_n   = s_q.ras_n;
    assign o_col_strobe_n   = s_q.cas_n;
    assign o_write_strobe_n = s_q.we_n;
    assign o_data_n         = s_q.dout_n;
    assign o_data_oe        = s_q.oe;
    assign o_rd_valid       = s_q.rvalid;
    assign o_rd_data        = s_q.rdata;

    sequence row_phase_s;
        o_row_strobe_n != dsp_pkg::GRP_IDLE;
    endsequence
    sequence col_phase_s;
        o_col_strobe_n != dsp_pkg::GRP_IDLE;
    endsequence

    one_select_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        $onehot0(~o_chip_sel_n))
        else $error("more than one chip select low");
    row_one_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        $onehot0(~o_row_strobe_n))
        else $error("more than one row strobe low");
    row_then_col_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce and row_phase_s) |=> col_phase_s)
        else $error("column strobe did not follow row strobe");
    col_same_grp_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce and row_phase_s) |=> o_col_strobe_n == $past(o_row_strobe_n))
        else $error("column strobe group differs from row");
    strobe_select_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (row_phase_s or col_phase_s) |-> o_chip_sel_n != dsp_pkg::CS_IDLE)
        else $error("strobe without chip select");
    write_oe_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_write_strobe_n != dsp_pkg::GRP_IDLE |-> (o_data_oe and col_phase_s))
        else $error("write strobe without driven data");
    read_no_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (col_phase_s and (o_write_strobe_n == dsp_pkg::GRP_IDLE)) |-> !o_data_oe)
        else $error("data driven during read");
    read_return_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce and col_phase_s and !o_data_oe) |-> ##3 o_rd_valid)
        else $error("read data not returned");
endmodule
`default_nettype wire

// ### dsp_top.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_top (
    // Clock and reset
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_arst_n,
    input  wire logic                         i_ce,
    // Per-port commands, index 0 primary, 1 secondary
    input  wire logic [1:0]                   i_cmd_valid,
    output logic      [1:0]                   o_cmd_ready,
    input  wire logic [1:0]                   i_cmd_write,
    input  wire logic [1:0][dsp_pkg::DIMM_W-1:0] i_cmd_dimm,
    input  wire logic [1:0][dsp_pkg::BANK_W-1:0] i_cmd_bank,
    input  wire logic [1:0][dsp_pkg::ADDR_W-1:0] i_cmd_row,
    input  wire logic [1:0][dsp_pkg::ADDR_W-1:0] i_cmd_col,
    input  wire logic [1:0]                   i_wr_valid,
    output logic      [1:0]                   o_wr_ready,
    input  wire logic [1:0][dsp_pkg::WORD_W-1:0] i_wr_data,
    output logic      [1:0]                   o_rd_valid,
    output logic      [1:0][dsp_pkg::WORD_W-1:0] o_rd_data,
    // Primary memory pins
    output logic [dsp_pkg::BANK_W-1:0]        o_primary_bank_addr,
    output logic [dsp_pkg::ADDR_W-1:0]        o_primary_mux_addr,
    output logic [dsp_pkg::CS_N-1:0]          o_primary_chip_sel_n,
    output logic [dsp_pkg::GRP_N-1:0]         o_primary_row_strobe_n,
    output logic [dsp_pkg::GRP_N-1:0]         o_primary_col_strobe_n,
    output logic [dsp_pkg::GRP_N-1:0]         o_primary_write_strobe_n,
    input  wire logic [dsp_pkg::DATA_W-1:0]   i_primary_data_n,
    input  wire logic [dsp_pkg::CHK_W-1:0]    i_primary_check_bits_n,
    output logic [dsp_pkg::DATA_W-1:0]        o_primary_data_n,
    output logic [dsp_pkg::CHK_W-1:0]         o_primary_check_bits_n,
    output logic                              o_primary_data_oe,
    // Secondary memory pins
    output logic [dsp_pkg::BANK_W-1:0]        o_secondary_bank_addr,
    output logic [dsp_pkg::ADDR_W-1:0]        o_secondary_mux_addr,
    output logic [dsp_pkg::CS_N-1:0]          o_secondary_chip_sel_n,
    output logic [dsp_pkg::GRP_N-1:0]         o_secondary_row_strobe_n,
    output logic [dsp_pkg::GRP_N-1:0]         o_secondary_col_strobe_n,
    output logic [dsp_pkg::GRP_N-1:0]         o_secondary_write_strobe_n,
    input  wire logic [dsp_pkg::DATA_W-1:0]   i_secondary_data_n,
    input  wire logic [dsp_pkg::CHK_W-1:0]    i_secondary_check_bits_n,
    output logic [dsp_pkg::DATA_W-1:0]        o_secondary_data_n,
    output logic [dsp_pkg::CHK_W-1:0]         o_secondary_check_bits_n,
    output logic                              o_secondary_data_oe,
    // Host clock and power good
    input  wire logic                         i_power_ok_source,
    output logic                              o_buffered_host_clock,
    output logic                              o_buffered_power_ok,
    // Management buses per carrier: 0 fru, 1 spd first, 2 spd second
    input  wire logic [1:0][dsp_pkg::I2C_N-1:0] i_mgmt_scl,
    input  wire logic [1:0][dsp_pkg::I2C_N-1:0] i_mgmt_sda_out,
    output logic      [1:0][dsp_pkg::I2C_N-1:0] o_mgmt_scl,
    output logic      [1:0][dsp_pkg::I2C_N-1:0] o_mgmt_sda_oe,
    output logic      [1:0][dsp_pkg::I2C_N-1:0] o_mgmt_sda_in,
    input  wire logic [1:0][dsp_pkg::I2C_N-1:0] i_mgmt_sda_pin,
    // Scan from system connector
    input  wire logic                         i_scan_test_mode,
    input  wire logic                         i_scan_tck,
    input  wire logic                         i_scan_tms,
    input  wire logic                         i_scan_tdi,
    input  wire logic                         i_scan_trst_n,
    output logic                              o_scan_tdo,
    output logic [1:0]                        o_carrier_tck,
    output logic [1:0]                        o_carrier_tms,
    output logic [1:0]                        o_carrier_tdi_oe,
    output logic [1:0]                        o_carrier_trst_n,
    input  wire logic [1:0]                   i_carrier_tdo
);
    logic [1:0][dsp_pkg::WORD_W-1:0] din_n;
    logic [1:0][dsp_pkg::WORD_W-1:0] dout_n;
    logic [1:0]                      oe;
    logic [1:0][dsp_pkg::BANK_W-1:0] bank;
    logic [1:0][dsp_pkg::ADDR_W-1:0] mux;
    logic [1:0][dsp_pkg::CS_N-1:0]   cs_n;
    logic [1:0][dsp_pkg::GRP_N-1:0]  ras_n;
    logic [1:0][dsp_pkg::GRP_N-1:0]  cas_n;
    logic [1:0][dsp_pkg::GRP_N-1:0]  we_n;
    logic [1:0]                      pwr_sync_q;

    assign din_n[0] = {i_primary_check_bits_n, i_primary_data_n};
    assign din_n[1] = {i_secondary_check_bits_n, i_secondary_data_n};

    for (genvar p = 0; p < 2; p++) begin : g_port
        dsp_port u_port (
            .i_clk_sys        (i_clk_sys),
            .i_arst_n         (i_arst_n),
            .i_ce             (i_ce),
            .i_cmd_valid      (i_cmd_valid[p]),
            .o_cmd_ready      (o_cmd_ready[p]),
            .i_cmd_write      (i_cmd_write[p]),
            .i_cmd_dimm       (i_cmd_dimm[p]),
            .i_cmd_bank       (i_cmd_bank[p]),
            .i_cmd_row        (i_cmd_row[p]),
            .i_cmd_col        (i_cmd_col[p]),
            .i_wr_valid       (i_wr_valid[p]),
            .o_wr_ready       (o_wr_ready[p]),
            .i_wr_data        (i_wr_data[p]),
            .o_rd_valid       (o_rd_valid[p]),
            .o_rd_data        (o_rd_data[p]),
            .o_bank_addr      (bank[p]),
            .o_mux_addr       (mux[p]),
            .o_chip_sel_n     (cs_n[p]),
            .o_row_strobe_n   (ras_n[p]),
            .o_col_strobe_n   (cas_n[p]),
            .o_write_strobe_n (we_n[p]),
            .i_data_n         (din_n[p]),
            .o_data_n         (dout_n[p]),
            .o_data_oe        (oe[p])
        );
    end

    assign o_primary_bank_addr        = bank[0];
    assign o_primary_mux_addr         = mux[0];
    assign o_primary_chip_sel_n       = cs_n[0];
    assign o_primary_row_strobe_n     = ras_n[0];
    assign o_primary_col_strobe_n     = cas_n[0];
    assign o_primary_write_strobe_n   = we_n[0];
    assign o_secondary_bank_addr      = bank[1];
    assign o_secondary_mux_addr       = mux[1];
    assign o_secondary_chip_sel_n     = cs_n[1];
    assign o_secondary_row_strobe_n   = ras_n[1];
    assign o_secondary_col_strobe_n   = cas_n[1];
    assign o_secondary_write_strobe_n = we_n[1];
    assign {o_primary_check_bits_n, o_primary_data_n}     = dout_n[0];
    assign {o_secondary_check_bits_n, o_secondary_data_n} = dout_n[1];
    assign o_primary_data_oe   = oe[0];
    assign o_secondary_data_oe = oe[1];

    // Power good through two flops
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwr_sync_q <= 2'h0;
        end else if (i_ce) begin
            pwr_sync_q <= {pwr_sync_q[0], i_power_ok_source};
        end
    end
    assign o_buffered_power_ok   = pwr_sync_q[1];
    assign o_buffered_host_clock = i_clk_sys;

    // Management buses pass through, open drain data
    assign o_mgmt_scl    = i_mgmt_scl;
    assign o_mgmt_sda_oe = ~i_mgmt_sda_out;
    assign o_mgmt_sda_in = i_mgmt_sda_pin;

    // Scan fans out to both carriers; test reset low outside test
    assign o_carrier_tck    = {2{i_scan_tck}};
    assign o_carrier_tms    = {2{i_scan_tms}};
    assign o_carrier_tdi_oe = {2{~i_scan_tdi & i_scan_test_mode}};
    assign o_carrier_trst_n = {2{i_scan_trst_n & i_scan_test_mode}};
    assign o_scan_tdo       = i_scan_test_mode ? i_carrier_tdo[1] : 1'b0;

    trst_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !i_scan_test_mode |-> o_carrier_trst_n == 2'h0)
        else $error("test reset not held low");
endmodule
`default_nettype wire

// ### dual_sdram_port_signal_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_sdram_port_signal_interface_bench;
    logic             clk = 1'b0, arst_n = 1'b0, ce = 1'b1;
    logic [1:0]       cv = 2'h0, cw = 2'h0, wv = 2'h0, ctdo = 2'h0;
    logic [1:0][4:0]  dm = 10'h000;
    logic [1:0][1:0]  bk = 4'h0;
    logic [1:0][12:0] rw = 26'h0, cl = 26'h0;
    logic [1:0][71:0] wd = 144'h0;
    logic [1:0][2:0]  scl_i = 6'h00, sda_o = 6'h00, far = 6'h00;
    logic             pok_src = 1'b0, tm = 1'b0, tck = 1'b0, tms = 1'b0, tdi = 1'b0;
    logic             trst_n = 1'b0;
    logic [2:0]       h = 3'h0;
    logic [25:0]      rnd;
    wire  [1:0]       cr, wr_rdy, rv, oe, ctck, ctms, ctdi_oe, ctrst;
    wire  [1:0][71:0] rd, dout, bus;
    wire  [1:0][1:0]  ba;
    wire  [1:0][12:0] ma;
    wire  [1:0][7:0]  cs;
    wire  [1:0][3:0]  ras, cas, we;
    wire  [1:0][2:0]  scl_o, sda_oe, sda_in, sda_p;
    wire              hclk, pok, tdo;
    logic [71:0]      mem [bit [33:0]];
    logic [71:0]      wq [2][$];
    int               seed = 32'h7F34;
    int               num_errors = 0, n_compared = 0;
    // Open-drain data line with pull-up
    assign sda_p = ~(sda_oe | far);
    initial forever #5 clk = ~clk;
    dsp_top DUT (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_ce(ce), .i_cmd_valid(cv), .o_cmd_ready(cr),
        .i_cmd_write(cw), .i_cmd_dimm(dm), .i_cmd_bank(bk), .i_cmd_row(rw), .i_cmd_col(cl),
        .i_wr_valid(wv), .o_wr_ready(wr_rdy), .i_wr_data(wd), .o_rd_valid(rv), .o_rd_data(rd),
        .o_primary_bank_addr(ba[0]), .o_primary_mux_addr(ma[0]), .o_primary_chip_sel_n(cs[0]),
        .o_primary_row_strobe_n(ras[0]), .o_primary_col_strobe_n(cas[0]),
        .o_primary_write_strobe_n(we[0]), .i_primary_data_n(bus[0][63:0]),
        .i_primary_check_bits_n(bus[0][71:64]), .o_primary_data_n(dout[0][63:0]),
        .o_primary_check_bits_n(dout[0][71:64]), .o_primary_data_oe(oe[0]),
        .o_secondary_bank_addr(ba[1]), .o_secondary_mux_addr(ma[1]),
        .o_secondary_chip_sel_n(cs[1]), .o_secondary_row_strobe_n(ras[1]),
        .o_secondary_col_strobe_n(cas[1]), .o_secondary_write_strobe_n(we[1]),
        .i_secondary_data_n(bus[1][63:0]), .i_secondary_check_bits_n(bus[1][71:64]),
        .o_secondary_data_n(dout[1][63:0]), .o_secondary_check_bits_n(dout[1][71:64]),
        .o_secondary_data_oe(oe[1]), .i_power_ok_source(pok_src),
        .o_buffered_host_clock(hclk), .o_buffered_power_ok(pok), .i_mgmt_scl(scl_i),
        .i_mgmt_sda_out(sda_o), .o_mgmt_scl(scl_o), .o_mgmt_sda_oe(sda_oe),
        .o_mgmt_sda_in(sda_in), .i_mgmt_sda_pin(sda_p), .i_scan_test_mode(tm),
        .i_scan_tck(tck), .i_scan_tms(tms), .i_scan_tdi(tdi), .i_scan_trst_n(trst_n),
        .o_scan_tdo(tdo), .o_carrier_tck(ctck), .o_carrier_tms(ctms),
        .o_carrier_tdi_oe(ctdi_oe), .o_carrier_trst_n(ctrst), .i_carrier_tdo(ctdo));
    for (genvar p = 0; p < 2; p++) begin : g_dimm
        dsp_dimm_model u_dimm (.i_clk_sys(clk), .i_bank_addr(ba[p]), .i_mux_addr(ma[p]),
            .i_chip_sel_n(cs[p]), .i_row_strobe_n(ras[p]), .i_col_strobe_n(cas[p]),
            .i_write_strobe_n(we[p]), .i_data_n(dout[p]), .i_data_oe(oe[p]), .o_bus_n(bus[p]));
    end
    task automatic chk(input logic [71:0] g, input logic [71:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wpush(input int p, input logic [71:0] v);
        int   t;
        logic rdy;
        t = 0;
        @(posedge clk);
        wv[p] <= 1'b1;
        wd[p] <= v;
        // Ready is settled mid-cycle; take it before the edge that uses it
        do begin
            @(negedge clk);
            rdy = wr_rdy[p];
            @(posedge clk);
            t++;
        end while (rdy !== 1'b1 && t < 50);
        wv[p] <= 1'b0;
        chk(rdy, 1'b1);
        wq[p].push_back(v);
    endtask
    task automatic cmd(input int p, input logic w, input logic [4:0] d, input logic [1:0] b,
                       input logic [12:0] r, input logic [12:0] c);
        logic [33:0] k;
        logic [3:0]  g;
        int          t;
        logic        rdy;
        k = {p[0], d, b, r, c};
        g = 4'h1 << d[4:3];
        t = 0;
        @(posedge clk);
        {cv[p], cw[p], dm[p], bk[p], rw[p], cl[p]} <= {1'b1, w, d, b, r, c};
        do begin
            @(negedge clk);
            rdy = cr[p];
            @(posedge clk);
            t++;
        end while (rdy !== 1'b1 && t < 50);
        cv[p] <= 1'b0;
        chk(rdy, 1'b1);
        #1;
        chk({cs[p], ras[p]}, {~(8'h01 << d[2:0]), ~g});
        chk({cas[p], ma[p], ba[p]}, {4'hF, r, b});
        @(posedge clk);
        #1;
        chk({cs[p], ras[p], cas[p]}, {~(8'h01 << d[2:0]), 4'hF, ~g});
        chk({we[p], ma[p], ba[p]}, {w ? ~g : 4'hF, c, b});
        if (w) begin
            chk({oe[p], dout[p]}, {1'b1, ~wq[p][0]});
            mem[k] = wq[p].pop_front();
        end
        @(posedge clk);
        #1;
        chk(rv[p], 1'b0);
        // Read word passes two pin flops before it is handed over
        if (!w) begin
            repeat (2) @(posedge clk);
            #1;
            chk({rv[p], rd[p]}, {1'b1, mem[k]});
        end
    endtask
    task automatic run(input int p);
        logic [4:0]  d [8];
        logic [1:0]  b [8];
        logic [12:0] r [8], c [8];
        logic [95:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {$random(seed), $random(seed), $random(seed)};
            {d[i], b[i], r[i], c[i]} = v[32:0];
            wpush(p, v[95:24]);
        end
        d[0] = 5'h00;
        d[1] = 5'h1F;
        #1;
        chk(wr_rdy[p], 1'b0);
        for (int i = 0; i < 16; i++) cmd(p, i < 8, d[i%8], b[i%8], r[i%8], c[i%8]);
    endtask
    task results;
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk({cs, ras, cas, we}, 40'hFFFFFFFFFF);
        chk({oe, rv, pok, ctrst}, 6'h00);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            rnd = 26'($random(seed));
            {pok_src, tm, tck, tms, tdi, trst_n, ctdo, scl_i, sda_o, far} <= rnd;
            #1;
            chk(pok, h[1]);
            h = {h[1:0], rnd[25]};
            chk({ctck, ctms, ctdi_oe, ctrst}, {{2{tck}}, {2{tms}}, {2{tm & ~tdi}}, {2{trst_n & tm}}});
            chk({tdo, hclk}, {tm & ctdo[1], clk});
            chk({scl_o, sda_oe, sda_in}, {scl_i, ~sda_o, ~(~sda_o | far)});
        end
        fork
            run(0);
            run(1);
        join
        results();
    end
    initial begin
        #20000;
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
